/* File: hw/sprx_pkg.sv */
// shared constants for the serial-to-parallel display-link receiver
package sprx_pkg;
    // link geometry
    localparam int LANES = 4;                  // serial data lanes
    localparam int BITS_PER_LANE = 7;          // bits per lane frame
    localparam int WORD_BITS = LANES * BITS_PER_LANE;  // 28-bit word
    localparam int FRAME_LAST = BITS_PER_LANE - 1;      // last bit index
    localparam logic [2:0] FRAME_LAST_IDX = 3'h6;       // same, 3 bits
    // system clock
    localparam int SYS_PERIOD_PS = 4000;       // 250 MHz
    // setup of the word ahead of the output clock fall (least time)
    localparam int T_SETUP_NS = 5;
    localparam int OCLK_HIGH_CYCLES =
        (T_SETUP_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
    // time from shutdown release to valid outputs (least time)
    localparam int T_RELOCK_US = 1000;
    localparam int RELOCK_CYCLES =
        (T_RELOCK_US * 1000000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
    // time from shutdown fall to off state (longest time)
    localparam int T_OFF_NS = 400;
    localparam int OFF_CYCLES = (T_OFF_NS * 1000) / SYS_PERIOD_PS;
    // relock counter width
    localparam int RELOCK_W = 18;
    // reset values
    localparam logic [WORD_BITS-1:0] WORD_RESET = 28'h0000000;
endpackage

/* File: hw/sprx_receiver.sv */
// four-lane 7:1 serial-to-parallel display-link receiver core
// Contract
// - four lanes each gather seven bits
// - four lane words form one 28-bit word
// - bits sampled at seven times link clock
// - one output word per link clock period
// - multiplier makes bit clock; output clock is built from clk_sys
// - output word valid at output clock fall
// - shutdown stops clocking, disables line receivers
// - shutdown low clears framing, relock and output registers, not the synchronisers
// - output bits reproduce transmitter bits unchanged
// - three-lane 21-bit transmitters also supported
// - outputs valid no sooner than 1 ms after release
// - off state within 400 ns of shutdown
`timescale 1ns/1ps
module sprx_receiver #(
    parameter int RELOCK_COUNT = sprx_pkg::RELOCK_CYCLES
) (
    // system side
    input wire logic clk_sys,
    input wire logic resetn,
    // shutdown pin, active low, asynchronous
    input wire logic shutdown_clear_n,
    // link side: bit clock from the clock multiplier
    input wire logic link_bit_clock,
    input wire logic [sprx_pkg::LANES-1:0] lane_serial_in,
    input wire logic forwarded_link_clock,
    // analog enables
    output logic lane_receiver_enable,
    output logic multiplier_enable,
    // parallel output bus
    output logic [sprx_pkg::WORD_BITS-1:0] parallel_word_out,
    output logic parallel_output_clock,
    output logic output_valid
);
    import sprx_pkg::*;

    // ---------------- link domain ----------------

    // pin synchronisers, lanes and clock sampled alike to keep alignment
    logic [LANES:0] pin_meta;        // first stage, read only by pin_sync
    logic [LANES:0] pin_sync;        // second stage
    // shutdown carried into the link domain
    logic sd_link_meta;
    logic sd_link_sync;
    // framing state
    logic fwd_prev;                  // last sampled forwarded clock
    logic [2:0] bit_cnt;             // samples since last rising edge
    logic [BITS_PER_LANE-1:0] shift [LANES];  // per-lane shift paths
    logic [WORD_BITS-1:0] hold_word; // last complete word, held a frame
    logic word_toggle;               // flips once per delivered word

    // decoded link events
    wire fwd_now = pin_sync[LANES];
    wire fwd_rise = fwd_now && !fwd_prev;
    wire frame_full = (bit_cnt == FRAME_LAST_IDX);
    wire frame_done = fwd_rise && frame_full && sd_link_sync;
    wire [WORD_BITS-1:0] shift_flat;

    // lane k fills bits 7k+6..7k; first received bit lands in the msb
    genvar gl;
    generate
        for (gl = 0; gl < LANES; gl++) begin : g_flat
            assign shift_flat[gl*BITS_PER_LANE +: BITS_PER_LANE] =
                shift[gl];
        end
    endgenerate

    // two-stage capture of lanes and forwarded clock
    always_ff @(posedge link_bit_clock or negedge resetn) begin
        if (!resetn) begin
            pin_meta <= '0;
            pin_sync <= '0;
            sd_link_meta <= 1'b0;
            sd_link_sync <= 1'b0;
        end else begin
            pin_meta <= {forwarded_link_clock, lane_serial_in};
            pin_sync <= pin_meta;
            sd_link_meta <= shutdown_clear_n;
            sd_link_sync <= sd_link_meta;
        end
    end

    // shift one bit per bit clock into every lane path
    always_ff @(posedge link_bit_clock or negedge resetn) begin
        if (!resetn) begin
            for (int k = 0; k < LANES; k++) begin
                shift[k] <= '0;
            end
        end else if (!sd_link_sync) begin
            for (int k = 0; k < LANES; k++) begin
                shift[k] <= '0;
            end
        end else begin
            // bit clock runs at seven times the forwarded clock
            for (int k = 0; k < LANES; k++) begin
                shift[k] <= {shift[k][BITS_PER_LANE-2:0],
                    pin_sync[k]};
            end
        end
    end

    // frame counter restart at each forwarded clock rise; word hand-off at a rise that ends an exact frame
    always_ff @(posedge link_bit_clock or negedge resetn) begin
        if (!resetn) begin
            fwd_prev <= 1'b0;
            bit_cnt <= 3'h0;
            hold_word <= WORD_RESET;
            word_toggle <= 1'b0;
        end else if (!sd_link_sync) begin
            // cleared while shut down
            fwd_prev <= 1'b0;
            bit_cnt <= 3'h0;
            hold_word <= WORD_RESET;
            word_toggle <= 1'b0;
        end else begin
            fwd_prev <= fwd_now;
            if (fwd_rise) begin
                // rise starts a frame; the sample now is its first bit
                bit_cnt <= 3'h0;
            end else if (bit_cnt != 3'h7) begin
                // saturate one past the frame end, so a stalled or idle
                // clock never looks like an exact seven-sample frame;
                // stopping at six would let the first rise after idle
                // deliver a word made of idle line noise
                bit_cnt <= bit_cnt + 3'h1;
            end
            if (frame_done) begin
                // only an exact seven-bit frame is delivered; a clock
                // outside the lock range shows up as short or long frames
                hold_word <= shift_flat;
                word_toggle <= !word_toggle;
            end
        end
    end

    // ---------------- system domain ----------------

    logic sd_meta;                   // shutdown, first stage
    logic sd_sync;                   // shutdown, second stage
    logic tog_meta;                  // word toggle, first stage
    logic tog_sync;                  // word toggle, second stage
    logic tog_prev;                  // for edge detection
    logic [RELOCK_W-1:0] relock_cnt; // time since release
    logic [1:0] oclk_cnt;            // output clock high time

    // decoded system events
    wire new_word = tog_sync ^ tog_prev;
    wire relock_done = (relock_cnt == RELOCK_COUNT[RELOCK_W-1:0]);
    wire oclk_last = (oclk_cnt == 2'(OCLK_HIGH_CYCLES - 1));

    // synchronisers for shutdown and the word toggle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sd_meta <= 1'b0;
            sd_sync <= 1'b0;
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_prev <= 1'b0;
        end else begin
            sd_meta <= shutdown_clear_n;
            sd_sync <= sd_meta;
            tog_meta <= word_toggle;
            tog_sync <= tog_meta;
            tog_prev <= tog_sync;
        end
    end

    // enables follow the synchronised pin, well inside the off time
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lane_receiver_enable <= 1'b0;
            multiplier_enable <= 1'b0;
        end else begin
            lane_receiver_enable <= sd_sync;
            multiplier_enable <= sd_sync;
        end
    end

    // relock wait: the multiplier needs time before words are trusted
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            relock_cnt <= '0;
            output_valid <= 1'b0;
        end else if (!sd_sync) begin
            relock_cnt <= '0;
            output_valid <= 1'b0;
        end else begin
            if (!relock_done) begin
                relock_cnt <= relock_cnt + 1'b1;
            end
            output_valid <= relock_done;
        end
    end

    // word load and output clock: word changes with the rise and is
    // stable through the fall; hold_word is stable for a whole frame,
    // so sampling it after the toggle is safe
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            parallel_word_out <= WORD_RESET;
            parallel_output_clock <= 1'b0;
            oclk_cnt <= 2'h0;
        end else if (!sd_sync) begin
            parallel_word_out <= WORD_RESET;
            parallel_output_clock <= 1'b0;
            oclk_cnt <= 2'h0;
        end else if (new_word && output_valid) begin
            // lane 3 is passed as is; with three lanes it means nothing
            parallel_word_out <= hold_word;
            parallel_output_clock <= 1'b1;
            oclk_cnt <= 2'h0;
        end else if (parallel_output_clock) begin
            // fall after the setup time has passed
            if (oclk_last) begin
                parallel_output_clock <= 1'b0;
            end
            oclk_cnt <= oclk_cnt + 2'h1;
        end
    end

    // ---------------- checks ----------------

    a_off_enables: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(sd_sync) |-> ##1 (!lane_receiver_enable && !multiplier_enable)
        [*2])
        else $error("enables not off after shutdown");
    a_enables_on: assert property (@(posedge clk_sys) disable iff (!resetn)
        sd_sync |=> (lane_receiver_enable && multiplier_enable))
        else $error("enables not on while running");
    a_clear_outputs: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        !sd_sync |=> (parallel_word_out == WORD_RESET
        && !parallel_output_clock && !output_valid))
        else $error("outputs not cleared in shutdown");
    a_valid_after_relock: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        $rose(output_valid) |-> $past(relock_done) && sd_sync)
        else $error("outputs valid before relock time");
    a_word_capture: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (new_word && output_valid && sd_sync) |=>
        (parallel_word_out == $past(hold_word)
        && parallel_output_clock))
        else $error("new word not presented");
    a_oclk_high_width: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        ($rose(parallel_output_clock) && sd_sync) |->
        parallel_output_clock [*2] ##1 !parallel_output_clock)
        else $error("output clock high time wrong");
    a_stable_at_fall: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        ($fell(parallel_output_clock) && sd_sync) |->
        parallel_word_out == $past(parallel_word_out, 2))
        else $error("word changed before output clock fall");
    a_frame_load: assert property (@(posedge link_bit_clock)
        disable iff (!resetn)
        frame_done |=> (hold_word == $past(shift_flat)
        && word_toggle != $past(word_toggle)))
        else $error("completed frame not loaded");
    a_short_frame_drop: assert property (@(posedge link_bit_clock)
        disable iff (!resetn)
        (fwd_rise && !frame_full) |=> $stable(word_toggle))
        else $error("short frame delivered a word");
    a_idle_no_word: assert property (@(posedge link_bit_clock)
        disable iff (!resetn)
        (fwd_rise && bit_cnt == 3'h7) |=> $stable(word_toggle))
        else $error("idle line delivered a word");
    a_word_only_rise: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        $changed(parallel_word_out) |->
        ($rose(parallel_output_clock) || parallel_word_out == WORD_RESET))
        else $error("word changed without output clock rise");
    a_valid_holds: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (output_valid && sd_sync) |=> output_valid)
        else $error("output valid dropped while running");
    a_link_cleared: assert property (@(posedge link_bit_clock)
        disable iff (!resetn)
        !sd_link_sync |=> (hold_word == WORD_RESET
        && bit_cnt == 3'h0 && !word_toggle))
        else $error("link state not cleared in shutdown");

    c_word_out: cover property (@(posedge clk_sys) disable iff (!resetn)
        $fell(parallel_output_clock) && output_valid);
    c_relocked: cover property (@(posedge clk_sys) disable iff (!resetn)
        $rose(output_valid));
    c_shutdown: cover property (@(posedge clk_sys) disable iff (!resetn)
        $fell(sd_sync) && output_valid);
    c_frame: cover property (@(posedge link_bit_clock)
        disable iff (!resetn) frame_done);
    // word seen at the first rise after an idle gap must be swallowed, not shown
    c_idle_rise: cover property (@(posedge link_bit_clock)
        disable iff (!resetn) fwd_rise && bit_cnt == 3'h7);

    // note on the two domains: the link side only ever hands over a
    // toggle; the word itself stays still for a whole frame, which is
    // far longer than the toggle takes to cross, so no gray code or
    // second handshake is needed for the 28 data bits

endmodule // sprx_receiver

/* File: test/sprx_tx_model.sv */
// behavioural serializing transmitter driving the receiver link side
`timescale 1ns/1ps
module sprx_tx_model
    import sprx_pkg::*;
(
    // bit clock from the clock multiplier
    input wire logic link_bit_clock,
    // serial lanes and forwarded clock
    output logic [LANES-1:0] lane_serial_in,
    output logic forwarded_link_clock
);
    logic [WORD_BITS:0] fifo [$]; // top bit flags a three-lane word
    logic [WORD_BITS:0] cur = '0; // word in flight
    int slot = 0; // bit slot within the frame
    logic busy = 1'b0; // a frame is on the wire

    // queue one word with its three-lane flag
    task automatic push(input logic three, input logic [WORD_BITS-1:0] w);
        fifo.push_back({three, w});
    endtask

    initial begin
        lane_serial_in = '0;
        forwarded_link_clock = 1'b0;
    end

    // one bit per lane per bit clock, first bit of a frame is lane bit 6
    always @(posedge link_bit_clock) begin
        if (slot == 0) begin
            busy = (fifo.size() != 0);
            if (busy) begin
                cur = fifo.pop_front();
            end
        end
        if (busy) begin
            // one forwarded clock period per seven bit clocks
            forwarded_link_clock <= (slot < 4);
            for (int l = 0; l < LANES; l++) begin
                lane_serial_in[l] <= cur[7 * l + FRAME_LAST - slot];
            end
            // three-lane sender: spare lane carries junk
            if (cur[WORD_BITS]) begin
                lane_serial_in[3] <= ~lane_serial_in[3];
            end
        end else begin
            // idle: clock stands low, lanes never hold a stale level
            forwarded_link_clock <= 1'b0;
            lane_serial_in <= ~lane_serial_in;
        end
        slot = (slot == FRAME_LAST) ? 0 : slot + 1;
    end
endmodule // sprx_tx_model

/* File: test/test_sprx_receiver.sv */
// self-checking bench for the display-link receiver core
`timescale 1ns/1ps
module test_sprx_receiver;
    import sprx_pkg::*;
    localparam int RELOCK = 20; // short relock count keeps the run brief
    // clocks, reset and shutdown
    logic clk_sys = 1'b0;
    logic link_bit_clock = 1'b0;
    logic resetn = 1'b0;
    logic shutdown_clear_n = 1'b1;
    // link and parallel side
    logic [LANES-1:0] lane_serial_in;
    logic forwarded_link_clock;
    logic lane_receiver_enable;
    logic multiplier_enable;
    logic [WORD_BITS-1:0] parallel_word_out;
    logic parallel_output_clock;
    logic output_valid;
    // scoreboard
    int n_mismatch = 0;
    int n_checks = 0;
    logic mon_on = 1'b0;
    logic [WORD_BITS-1:0] exp_q [$];
    logic [WORD_BITS-1:0] mask_q [$];
    // ordinary cases: three-lane flag beside the word sent
    typedef struct {logic three; logic [WORD_BITS-1:0] word;} sprx_row_t;
    sprx_row_t rows [8] = '{'{1'b0, 28'h0000001}, '{1'b0, 28'h8000000},
        '{1'b0, 28'hAAAAAAA}, '{1'b0, 28'h5555555}, '{1'b0, 28'hFFFFFFF},
        '{1'b0, 28'h0123456}, '{1'b1, 28'h01ABCDE}, '{1'b0, 28'h7F0003F}};

    always #2 clk_sys = ~clk_sys;
    // link clock offset so its phase is unrelated to clk_sys
    initial begin
        #1.3;
        forever #32 link_bit_clock = ~link_bit_clock;
    end

    sprx_receiver #(.RELOCK_COUNT(RELOCK)) DUT (
        .clk_sys(clk_sys), .resetn(resetn),
        .shutdown_clear_n(shutdown_clear_n),
        .link_bit_clock(link_bit_clock), .lane_serial_in(lane_serial_in),
        .forwarded_link_clock(forwarded_link_clock),
        .lane_receiver_enable(lane_receiver_enable),
        .multiplier_enable(multiplier_enable),
        .parallel_word_out(parallel_word_out),
        .parallel_output_clock(parallel_output_clock),
        .output_valid(output_valid));
    sprx_tx_model u_tx (.link_bit_clock(link_bit_clock),
        .lane_serial_in(lane_serial_in),
        .forwarded_link_clock(forwarded_link_clock));

    task automatic check_word(input string what,
        input logic [WORD_BITS-1:0] exp, input logic [WORD_BITS-1:0] seen);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic check_bit(input string what, input logic exp,
        input logic seen);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // every row back to back, then a frame that flushes the last word
    task automatic send_rows;
        foreach (rows[i]) begin
            u_tx.push(rows[i].three, rows[i].word);
            exp_q.push_back(rows[i].word);
            mask_q.push_back(rows[i].three ? 28'h01FFFFF : 28'hFFFFFFF);
        end
        u_tx.push(1'b0, 28'h0000000);
        for (int i = 0; i < 9000 && exp_q.size() != 0; i++) begin
            @(negedge clk_sys);
        end
        check_bit("all words shown", 1'b1, exp_q.size() == 0);
    endtask

    // word is taken at the fall of the output clock
    always @(negedge parallel_output_clock) begin : mon
        logic [WORD_BITS-1:0] m;
        if (mon_on && exp_q.size() == 0) begin
            check_bit("spare word", 1'b0, 1'b1);
        end else if (mon_on) begin
            m = mask_q.pop_front();
            check_word("word", exp_q.pop_front() & m, parallel_word_out & m);
        end
    end

    // watchdog: a full run takes about 10.5 us
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end

    initial begin
        repeat (12) @(negedge clk_sys);
        check_word("word in reset", WORD_RESET, parallel_word_out);
        check_bit("enable in reset", 1'b0, lane_receiver_enable);
        @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (10) @(negedge clk_sys);
        check_bit("receivers on", 1'b1, lane_receiver_enable);
        check_bit("multiplier on", 1'b1, multiplier_enable);
        check_bit("valid early", 1'b0, output_valid);
        repeat (30) @(negedge clk_sys);
        check_bit("valid late", 1'b1, output_valid);
        mon_on = 1'b1;
        send_rows();
        // shutdown while frames still arrive
        @(posedge clk_sys);
        shutdown_clear_n <= 1'b0;
        u_tx.push(1'b0, 28'h1234567);
        u_tx.push(1'b0, 28'h7654321);
        repeat (4) @(negedge clk_sys);
        check_bit("receivers off", 1'b0, lane_receiver_enable);
        check_bit("multiplier off", 1'b0, multiplier_enable);
        check_word("word cleared", WORD_RESET, parallel_word_out);
        check_bit("valid cleared", 1'b0, output_valid);
        check_bit("clock cleared", 1'b0, parallel_output_clock);
        repeat (500) @(negedge clk_sys);
        @(posedge clk_sys);
        shutdown_clear_n <= 1'b1;
        repeat (40) @(negedge clk_sys);
        check_bit("valid again", 1'b1, output_valid);
        send_rows();
        finish_test();
    end
endmodule // test_sprx_receiver
